/* File: design/trace_trigger_and_capture_fifo.sv */
// Trace trigger, break control and change-of-flow capture top level
// Summary of operation
// - A-only mode sets match_a_flag on every comparator A match.
// - A-or-B mode sets the flag of each comparator that matches.
// - A-then-B compares B only after A matched; each match sets its flag.
// - Event-only-B sets the B flag and always runs begin-type.
// - A-then-event-B waits for A, sets flags, always begin-type.
// - A-and-B sets both flags only on same-cycle address and data match.
// - A-and-not-B sets both flags when A matches and B does not.
// - Full modes, tag breaks in end runs, use comparator A alone.
// - Inside range sets both flags when A <= address <= B.
// - Outside range: A flag below A, B flag above B.
// - End runs capture until trigger; break at trigger if enabled.
// - Begin runs start at trigger; break on FIFO full if enabled.
// - Eight-word FIFO; event modes store data, upper bytes read zero.
// - Indirect flow stores current address; branch stores previous minus two.
// - Begin-armed stores nothing until trigger, stays armed for 8 words.
// - End-armed stores until trigger, then disarms; trigger flow is stored.
// - Event-only modes never run end-type capture.
// - Host reads oldest first when enabled and idle; low read advances.
// - Reading while armed returns oldest entry and does not advance.
// - Profile low-byte read while idle stores current opcode address.
// - Arming clears the A, B and C match flags.
// - Qualify off: match triggers; on: tracking must confirm A except in event and range modes, B only in A-or-B and A-then-B.
`timescale 1ns/1ps
`default_nettype none
module trace_trigger_and_capture_fifo
(
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Configuration
  input wire logic debugEnableBit,
  input wire logic armRequest,
  input wire logic disarmRequest,
  input wire logic beginSelect,
  input wire logic opcodeQualifySelect,
  input wire logic breakRequestEnable,
  input wire logic tagSelect,
  input wire logic profileMode,
  input wire logic [3:0] trigMode,
  // Comparator results
  input wire logic aEq,
  input wire logic bEq,
  input wire logic cEq,
  input wire logic addrGeA,
  input wire logic addrLeB,
  input wire logic addrLtA,
  input wire logic addrGtB,
  input wire logic aExec,
  input wire logic bExec,
  // CPU core
  input wire logic [trace_pkg::ADDR_W-1:0] coreAddr,
  input wire logic corePaged,
  input wire logic [trace_pkg::DATA_W-1:0] coreData,
  input wire logic [1:0] coreCof,
  input wire logic [trace_pkg::ADDR_W-1:0] opcodeAddr,
  input wire logic opcodePaged,
  output logic forceBreak,
  output logic tagBreak,
  // Host read port
  input wire logic readLow,
  output logic [7:0] fifoLowByte,
  output logic [7:0] fifoHighByte,
  output logic [7:0] fifoExtensionByte,
  output logic [trace_pkg::CNT_W-1:0] validWordCount,
  // Status
  output logic captureActiveFlag,
  output logic matchAFlag,
  output logic matchBFlag,
  output logic matchCFlag
);
  import trace_pkg::*;

  logic armed_r, armed_nxt;
  logic triggered_r, triggered_nxt;
  logic aSeen_r, aSeen_nxt;
  logic flagA_r, flagA_nxt, flagB_r, flagB_nxt, flagC_r, flagC_nxt;
  logic runEvent_r, runEvent_nxt;
  logic runBegin_r, runBegin_nxt;
  logic [ADDR_W-1:0] prevAddr_r, prevAddr_nxt;
  logic forceBreak_r, forceBreak_nxt, tagBreak_r, tagBreak_nxt;
  logic [7:0] lowOut_r, lowOut_nxt, highOut_r, highOut_nxt, extOut_r, extOut_nxt;

  logic hitA, hitB, trigger, eventMode;
  logic push, pop, clear, full, armNow, beginType;
  logic [WORD_W-1:0] pushWord, headWord, cofWord;
  logic [CNT_W-1:0] count;
  logic cofAny, breakTrig;

  // Comparator qualification per trigger mode
  trace_match uMatch
  (
    .trigMode(trigMode),
    .opcodeQualify(opcodeQualifySelect),
    .aSeen(aSeen_r),
    .aEq(aEq),
    .bEq(bEq),
    .addrGeA(addrGeA),
    .addrLeB(addrLeB),
    .addrLtA(addrLtA),
    .addrGtB(addrGtB),
    .aExec(aExec),
    .bExec(bExec),
    .hitA(hitA),
    .hitB(hitB),
    .trigger(trigger),
    .eventMode(eventMode)
  );

  // Capture store; overwrites the oldest word once full
  trace_fifo uFifo
  (
    .clk(clk),
    .reset(reset),
    .clear(clear),
    .push(push),
    .pushWord(pushWord),
    .pop(pop),
    .headWord(headWord),
    .count(count),
    .full(full)
  );

  // Event-only modes force begin-type capture
  assign beginType = beginSelect || eventMode;
  assign armNow = armRequest && debugEnableBit;
  assign clear = armNow && !armed_r;
  assign cofAny = coreCof[COF_INDIRECT] || coreCof[COF_BRANCH];

  // Flow address selection
  always_comb
  begin
    // Branch stores point back at the branch, two bytes before last cycle's address
    prevAddr_nxt = coreAddr;
    cofWord = {corePaged, coreAddr};
    if (!coreCof[COF_INDIRECT])
      cofWord = {corePaged, ADDR_W'(prevAddr_r - BRANCH_BACKOFF)};
  end

  // Full modes with tagging in end runs break on A alone
  // Such a tag break never ends the run; only the trigger does
  always_comb
  begin
    breakTrig = trigger;
    if (tagSelect && !runBegin_r &&
        ((trig_mode_e'(trigMode) == MODE_A_AND_B) ||
         (trig_mode_e'(trigMode) == MODE_A_AND_NOT_B)))
      breakTrig = aEq && (!opcodeQualifySelect || aExec);
  end

  // One store source per cycle: a live run, or a profile read while idle
  always_comb
  begin
    push = 1'b0;
    pushWord = cofWord;
    pop = 1'b0;
    if (armed_r)
    begin
      if (runEvent_r)
      begin
        // Event words keep the high and extension bytes at zero
        pushWord = {2'b00, BYTE_ZERO, coreData};
        push = hitB && (triggered_r || trigger) && !full;
      end
      else if (runBegin_r)
        push = cofAny && (triggered_r || trigger) && !full;
      else
        push = cofAny;
    end
    else if (readLow && debugEnableBit)
    begin
      if (profileMode)
      begin
        push = 1'b1;
        pushWord = {opcodePaged, opcodeAddr};
      end
      else
        pop = 1'b1;
    end
  end

  // Arming wins over any flag set in the same cycle; flags only move while armed
  always_comb
  begin
    armed_nxt = armed_r;
    triggered_nxt = triggered_r;
    aSeen_nxt = aSeen_r;
    runEvent_nxt = runEvent_r;
    runBegin_nxt = runBegin_r;
    flagA_nxt = flagA_r;
    flagB_nxt = flagB_r;
    flagC_nxt = flagC_r;
    forceBreak_nxt = 1'b0;
    tagBreak_nxt = 1'b0;
    if (clear)
    begin
      armed_nxt = 1'b1;
      triggered_nxt = 1'b0;
      aSeen_nxt = 1'b0;
      runEvent_nxt = eventMode;
      runBegin_nxt = beginType;
      flagA_nxt = 1'b0;
      flagB_nxt = 1'b0;
      flagC_nxt = 1'b0;
    end
    else if (armed_r)
    begin
      flagA_nxt = flagA_r || hitA;
      flagB_nxt = flagB_r || hitB;
      flagC_nxt = flagC_r || cEq;
      aSeen_nxt = aSeen_r || hitA;
      if (trigger)
        triggered_nxt = 1'b1;
      // Begin runs end on the eighth store, not on the trigger
      if (runBegin_r)
      begin
        if (full || (push && (count == COUNT_FULL - COUNT_ONE)))
        begin
          armed_nxt = 1'b0;
          forceBreak_nxt = breakRequestEnable;
        end
      end
      else if (trigger || breakTrig)
      begin
        if (trigger)
          armed_nxt = 1'b0;
        tagBreak_nxt = breakRequestEnable && tagSelect && breakTrig;
        forceBreak_nxt = breakRequestEnable && !tagSelect && trigger;
      end
      // A host abort ends the run with no break request
      if (disarmRequest || !debugEnableBit)
        armed_nxt = 1'b0;
    end
  end

  // Output bytes are registered; armed reads show head without shifting
  always_comb
  begin
    lowOut_nxt = headWord[LOW_LSB +: 8];
    highOut_nxt = headWord[HIGH_LSB +: 8];
    extOut_nxt = {6'h00, headWord[PAGED_BIT], headWord[EXT_LSB]};
    if (runEvent_r)
    begin
      highOut_nxt = BYTE_ZERO;
      extOut_nxt = BYTE_ZERO;
    end
  end

  // Registers only; every decision sits in the blocks above
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      armed_r <= 1'b0;
      triggered_r <= 1'b0;
      aSeen_r <= 1'b0;
      runEvent_r <= 1'b0;
      runBegin_r <= 1'b0;
      flagA_r <= 1'b0;
      flagB_r <= 1'b0;
      flagC_r <= 1'b0;
      prevAddr_r <= '0;
      forceBreak_r <= 1'b0;
      tagBreak_r <= 1'b0;
      lowOut_r <= '0;
      highOut_r <= '0;
      extOut_r <= '0;
    end
    else
    begin
      armed_r <= armed_nxt;
      triggered_r <= triggered_nxt;
      aSeen_r <= aSeen_nxt;
      runEvent_r <= runEvent_nxt;
      runBegin_r <= runBegin_nxt;
      flagA_r <= flagA_nxt;
      flagB_r <= flagB_nxt;
      flagC_r <= flagC_nxt;
      prevAddr_r <= prevAddr_nxt;
      forceBreak_r <= forceBreak_nxt;
      tagBreak_r <= tagBreak_nxt;
      lowOut_r <= lowOut_nxt;
      highOut_r <= highOut_nxt;
      extOut_r <= extOut_nxt;
    end
  end

  // Outputs come straight from flip-flops or the FIFO count register
  assign captureActiveFlag = armed_r;
  assign matchAFlag = flagA_r;
  assign matchBFlag = flagB_r;
  assign matchCFlag = flagC_r;
  assign forceBreak = forceBreak_r;
  assign tagBreak = tagBreak_r;
  assign fifoLowByte = lowOut_r;
  assign fifoHighByte = highOut_r;
  assign fifoExtensionByte = extOut_r;
  assign validWordCount = count;
endmodule
`default_nettype wire

/* File: design/trace_pkg.sv */
// Shared constants and types for the trace trigger and capture logic
`default_nettype none
package trace_pkg;
  localparam int ADDR_W = 17;
  localparam int DATA_W = 8;
  localparam int FIFO_DEPTH = 8;
  localparam int PTR_W = 3;
  localparam int CNT_W = 4;
  // Word layout: paged flag, 17-bit address
  localparam int WORD_W = ADDR_W + 1;
  localparam int PAGED_BIT = ADDR_W;
  localparam int LOW_LSB = 0;
  localparam int HIGH_LSB = 8;
  localparam int EXT_LSB = 16;
  localparam int EXT_W = 2;
  localparam logic [ADDR_W-1:0] BRANCH_BACKOFF = 17'h00002;
  localparam logic [CNT_W-1:0] COUNT_FULL = 4'h8;
  localparam logic [CNT_W-1:0] COUNT_ONE = 4'h1;
  localparam logic [PTR_W-1:0] PTR_ONE = 3'h1;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam int COF_INDIRECT = 1;
  localparam int COF_BRANCH = 0;

  typedef enum logic [3:0] {
    MODE_A_ONLY,
    MODE_A_OR_B,
    MODE_A_THEN_B,
    MODE_EVENT_B,
    MODE_A_THEN_EVENT_B,
    MODE_A_AND_B,
    MODE_A_AND_NOT_B,
    MODE_INSIDE,
    MODE_OUTSIDE
  } trig_mode_e;
endpackage
`default_nettype wire

/* File: design/trace_fifo.sv */
// Eight-word capture store with count and read-out shifting
`timescale 1ns/1ps
`default_nettype none
module trace_fifo
(
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Control
  input wire logic clear,
  input wire logic push,
  input wire logic [trace_pkg::WORD_W-1:0] pushWord,
  input wire logic pop,
  // State
  output logic [trace_pkg::WORD_W-1:0] headWord,
  output logic [trace_pkg::CNT_W-1:0] count,
  output logic full
);
  import trace_pkg::*;

  logic [WORD_W-1:0] mem_r [FIFO_DEPTH];
  logic [WORD_W-1:0] mem_nxt [FIFO_DEPTH];
  logic [PTR_W-1:0] wrPtr_r, wrPtr_nxt, rdPtr_r, rdPtr_nxt;
  logic [CNT_W-1:0] count_r, count_nxt;

  assign full = (count_r == COUNT_FULL);
  assign count = count_r;
  assign headWord = mem_r[rdPtr_r];

  genvar gi;
  generate
    for (gi = 0; gi < FIFO_DEPTH; gi++)
    begin : gEntry
      always_comb
      begin
        mem_nxt[gi] = mem_r[gi];
        if (push && (wrPtr_r == PTR_W'(gi)))
          mem_nxt[gi] = pushWord;
      end
      always_ff @(posedge clk or posedge reset)
      begin
        if (reset)
          mem_r[gi] <= '0;
        else
          mem_r[gi] <= mem_nxt[gi];
      end
    end
  endgenerate

  always_comb
  begin
    wrPtr_nxt = wrPtr_r;
    rdPtr_nxt = rdPtr_r;
    count_nxt = count_r;
    if (clear)
    begin
      wrPtr_nxt = '0;
      rdPtr_nxt = '0;
      count_nxt = '0;
    end
    else
    begin
      if (pop)
        rdPtr_nxt = rdPtr_r + PTR_ONE;
      if (push)
      begin
        wrPtr_nxt = wrPtr_r + PTR_ONE;
        if (full)
          rdPtr_nxt = wrPtr_r + PTR_ONE;
        else
          count_nxt = count_r + COUNT_ONE;
      end
    end
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      wrPtr_r <= '0;
      rdPtr_r <= '0;
      count_r <= '0;
    end
    else
    begin
      wrPtr_r <= wrPtr_nxt;
      rdPtr_r <= rdPtr_nxt;
      count_r <= count_nxt;
    end
  end
endmodule
`default_nettype wire

/* File: design/trace_match.sv */
// Trigger evaluator: per-mode comparator qualification into hit strobes
`timescale 1ns/1ps
`default_nettype none
module trace_match
(
  // Mode and qualifiers
  input wire logic [3:0] trigMode,
  input wire logic opcodeQualify,
  input wire logic aSeen,
  // Raw comparator results
  input wire logic aEq,
  input wire logic bEq,
  input wire logic addrGeA,
  input wire logic addrLeB,
  input wire logic addrLtA,
  input wire logic addrGtB,
  input wire logic aExec,
  input wire logic bExec,
  // Results
  output logic hitA,
  output logic hitB,
  output logic trigger,
  output logic eventMode
);
  import trace_pkg::*;

  logic qa, qb;

  always_comb
  begin
    // Opcode tracking qualifies A outside event and range modes, and B only in A-or-B and A-then-B
    qa = aEq && (!opcodeQualify || aExec);
    qb = bEq && (!opcodeQualify || bExec);
    hitA = 1'b0;
    hitB = 1'b0;
    trigger = 1'b0;
    eventMode = 1'b0;
    unique case (trig_mode_e'(trigMode))
      MODE_A_ONLY:
      begin
        hitA = qa;
        trigger = qa;
      end
      MODE_A_OR_B:
      begin
        hitA = qa;
        hitB = qb;
        trigger = qa || qb;
      end
      MODE_A_THEN_B:
      begin
        hitA = qa;
        hitB = aSeen && qb;
        trigger = hitB;
      end
      MODE_EVENT_B:
      begin
        eventMode = 1'b1;
        hitB = bEq;
        trigger = hitB;
      end
      MODE_A_THEN_EVENT_B:
      begin
        eventMode = 1'b1;
        hitA = aEq;
        hitB = aSeen && bEq;
        trigger = hitB;
      end
      MODE_A_AND_B:
      begin
        hitA = qa && bEq;
        hitB = qa && bEq;
        trigger = hitA;
      end
      MODE_A_AND_NOT_B:
      begin
        hitA = qa && !bEq;
        hitB = qa && !bEq;
        trigger = hitA;
      end
      MODE_INSIDE:
      begin
        hitA = addrGeA && addrLeB;
        hitB = addrGeA && addrLeB;
        trigger = hitA;
      end
      MODE_OUTSIDE:
      begin
        hitA = addrLtA;
        hitB = addrGtB;
        trigger = hitA || hitB;
      end
      // Unused codes never trigger
      default:
      begin
        trigger = 1'b0;
      end
    endcase
  end
endmodule
`default_nettype wire

/* File: tb/trace_asserts.sv */
// Port-level checker for the trace trigger and capture block
`timescale 1ns/1ps
`default_nettype none
module trace_asserts
(
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Configuration
  input wire logic debugEnableBit,
  input wire logic armRequest,
  input wire logic beginSelect,
  input wire logic opcodeQualifySelect,
  input wire logic breakRequestEnable,
  input wire logic tagSelect,
  input wire logic profileMode,
  input wire logic [3:0] trigMode,
  // Comparators and host
  input wire logic aEq,
  input wire logic addrGeA,
  input wire logic addrLeB,
  input wire logic addrGtB,
  input wire logic readLow,
  // Results
  input wire logic forceBreak,
  input wire logic tagBreak,
  input wire logic [7:0] fifoHighByte,
  input wire logic [7:0] fifoExtensionByte,
  input wire logic [trace_pkg::CNT_W-1:0] validWordCount,
  input wire logic captureActiveFlag,
  input wire logic matchAFlag,
  input wire logic matchBFlag,
  input wire logic matchCFlag
);
  import trace_pkg::*;
  default clocking @(posedge clk);
  endclocking
  default disable iff (reset);
  // Armed with plain comparator triggering
  wire logic armQ = captureActiveFlag && !opcodeQualifySelect;
  arm_starts_a: assert property (armRequest && debugEnableBit && !captureActiveFlag |=>
    captureActiveFlag && !matchAFlag && !matchBFlag && !matchCFlag)
    else $error("arming did not start a clean run");
  a_only_flag_a: assert property (armQ && trigMode == 4'h0 && aEq |=> matchAFlag)
    else $error("A match left its flag clear");
  inside_flags_a: assert property (armQ && trigMode == 4'h7 && addrGeA && addrLeB
    |=> matchAFlag && matchBFlag) else $error("inside range left flags clear");
  outside_b_a: assert property (armQ && trigMode == 4'h8 && addrGtB |=> matchBFlag)
    else $error("above B left its flag clear");
  full_pair_a: assert property (captureActiveFlag && trigMode inside {4'h5, 4'h6, 4'h7}
    |-> matchAFlag == matchBFlag) else $error("paired mode flags differ");
  end_trigger_a: assert property (armQ && !beginSelect && trigMode == 4'h0 && aEq &&
    !armRequest |=> !captureActiveFlag && forceBreak == ($past(breakRequestEnable) &&
    !$past(tagSelect))) else $error("end trigger did not stop the run");
  brk_pulse_a: assert property (forceBreak || tagBreak |=> !forceBreak && !tagBreak)
    else $error("break request longer than one cycle");
  no_brk_a: assert property (!$past(breakRequestEnable) |-> !forceBreak && !tagBreak)
    else $error("break request while breaks disabled");
  count_cap_a: assert property (validWordCount <= 4'h8)
    else $error("valid word count above eight");
  read_keeps_a: assert property (readLow && !captureActiveFlag && !profileMode && !armRequest
    |=> $stable(validWordCount)) else $error("host read changed the count");
  event_upper_a: assert property (captureActiveFlag && trigMode inside {4'h3, 4'h4}
    |=> fifoHighByte == 8'h00 && fifoExtensionByte == 8'h00)
    else $error("event run upper bytes not zero");
  cover property (forceBreak);
  cover property (tagBreak);
  cover property ($fell(captureActiveFlag) && validWordCount == 4'h8);
endmodule
bind trace_trigger_and_capture_fifo trace_asserts u_trace_asserts (.clk, .reset,
  .debugEnableBit, .armRequest, .beginSelect, .opcodeQualifySelect, .breakRequestEnable,
  .tagSelect, .profileMode, .trigMode, .aEq, .addrGeA, .addrLeB, .addrGtB, .readLow,
  .forceBreak, .tagBreak, .fifoHighByte, .fifoExtensionByte, .validWordCount,
  .captureActiveFlag, .matchAFlag, .matchBFlag, .matchCFlag);
`default_nettype wire

/* File: tb/core_model.sv */
// CPU core stand-in: bus values and a tally of break requests
`timescale 1ns/1ps
`default_nettype none
module core_model
(
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Bench control
  input wire logic [31:0] rnd,
  input wire logic [8:0] dataFix,
  input wire logic pagedSel,
  // Core bus
  output logic [trace_pkg::ADDR_W-1:0] coreAddr = 17'h00000,
  output logic corePaged = 1'b0,
  output logic [trace_pkg::DATA_W-1:0] coreData = 8'h00,
  output logic [trace_pkg::ADDR_W-1:0] opcodeAddr = 17'h00000,
  output logic opcodePaged = 1'b0,
  output logic [trace_pkg::ADDR_W-1:0] prevAddr = 17'h00000,
  // Break requests
  input wire logic forceBreak,
  input wire logic tagBreak,
  output logic [15:0] brks
);
  import trace_pkg::*;
  // Bus moves on the falling edge, settled well before sampling
  always @(negedge clk)
  begin
    coreAddr <= rnd[16:0];
    corePaged <= pagedSel;
    coreData <= dataFix[8] ? dataFix[7:0] : rnd[31:24];
    opcodeAddr <= rnd[27:11];
    opcodePaged <= rnd[3];
  end
  // Last cycle's address, the base of a taken-branch store
  always @(posedge clk)
    prevAddr <= coreAddr;
  always @(posedge clk or posedge reset)
    if (reset)
      brks <= 16'h0000;
    else
      brks <= brks + {7'h00, tagBreak, 7'h00, forceBreak};
endmodule
`default_nettype wire

/* File: tb/tb_top.sv */
// Self-checking bench for the trace trigger and capture block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import trace_pkg::*;
  localparam logic [8:0] PH [3] = '{9'h029, 9'h052, 9'h01F};
  localparam logic [1:0] FE [3][9] = '{'{2, 2, 2, 0, 2, 0, 3, 0, 2},
    '{2, 3, 3, 1, 3, 0, 3, 0, 3}, '{2, 3, 3, 1, 3, 3, 3, 3, 3}};
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic debugEnableBit = 1'b1;
  logic armRequest = 1'b0;
  logic disarmRequest = 1'b0;
  logic [7:0] cfg = 8'h00;
  logic [8:0] cmp = 9'h000;
  logic [1:0] coreCof = 2'b00;
  logic readLow = 1'b0;
  logic profileMode = 1'b0;
  logic [31:0] lfsr = 32'h00000061;
  logic [8:0] dataFix = 9'h000;
  logic pagedSel = 1'b0;
  logic [ADDR_W-1:0] coreAddr, opcodeAddr, prevAddr;
  logic corePaged, opcodePaged, forceBreak, tagBreak;
  logic [7:0] coreData, lowB, highB, extB;
  logic [CNT_W-1:0] validWordCount;
  logic captureActiveFlag, matchAFlag, matchBFlag, matchCFlag;
  logic [15:0] brks, b0;
  logic [17:0] expQ [$];
  logic [17:0] pw;
  int fail_count = 0;
  int n_compared = 0;
  int cycles = 0;
  always #2.5 clk = ~clk;
  trace_trigger_and_capture_fifo u_trace_trigger_and_capture_fifo (.clk, .reset,
    .debugEnableBit, .armRequest, .disarmRequest, .beginSelect(cfg[3]),
    .opcodeQualifySelect(cfg[2]), .breakRequestEnable(cfg[1]), .tagSelect(cfg[0]),
    .profileMode, .trigMode(cfg[7:4]), .aEq(cmp[0]), .bEq(cmp[1]), .cEq(cmp[2]),
    .addrGeA(cmp[3]), .addrLeB(cmp[4]), .addrLtA(cmp[5]), .addrGtB(cmp[6]),
    .aExec(cmp[7]), .bExec(cmp[8]), .coreAddr, .corePaged, .coreData, .coreCof,
    .opcodeAddr, .opcodePaged, .forceBreak, .tagBreak, .readLow, .fifoLowByte(lowB),
    .fifoHighByte(highB), .fifoExtensionByte(extB), .validWordCount, .captureActiveFlag,
    .matchAFlag, .matchBFlag, .matchCFlag);
  core_model u_core_model (.clk, .reset, .rnd(lfsr), .dataFix, .pagedSel, .coreAddr,
    .corePaged, .coreData, .opcodeAddr, .opcodePaged, .prevAddr, .forceBreak, .tagBreak,
    .brks);
  function automatic logic [31:0] lfsrNext(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  function automatic logic [17:0] storeWord(input logic [1:0] cof);
    return {pagedSel, cof[1] ? coreAddr : prevAddr - BRANCH_BACKOFF};
  endfunction
  always @(posedge clk)
    lfsr <= lfsrNext(lfsr);
  task automatic check(input string what, input logic [23:0] seen, input logic [23:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic results();
    $display("Compared %0d, mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // Disarm first, as arming is ignored while a run is live; new setup once it has ended
  task automatic arm(input logic [7:0] c);
    @(negedge clk);
    disarmRequest = 1'b1;
    @(negedge clk);
    disarmRequest = 1'b0;
    cfg = c;
    armRequest = 1'b1;
    @(negedge clk);
    armRequest = 1'b0;
  endtask
  task automatic cyc(input logic [1:0] cof, input logic [8:0] c, input logic rd);
    @(negedge clk);
    coreCof = cof;
    cmp = c;
    readLow = rd;
    #1;
    if (cof != 2'b00)
      expQ.push_back(storeWord(cof));
  endtask
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      fail_count++;
      results();
    end
  end
  initial
  begin
    repeat (12) @(posedge clk);
    @(negedge clk);
    reset = 1'b0;
    for (int k = 0; k < 2; k++)
    begin
      pagedSel = lfsr[5];
      arm({4'h0, 1'b0, k[0], 1'b1, k[0]});
      expQ.delete();
      b0 = brks;
      for (int i = 0; i < 10; i++)
        cyc(i[0] ? 2'b01 : 2'b10, {8'h00, k[0]}, i == 9);
      cyc(2'b10, 9'h181, 1'b0);
      cyc(2'b10, 9'h000, 1'b0);
      void'(expQ.pop_back());
      repeat (2) cyc(2'b00, 9'h000, 1'b0);
      check("armed", captureActiveFlag, 0);
      check("count", validWordCount, COUNT_FULL);
      check("breaks", brks, b0 + (k ? 16'h0100 : 16'h0001));
      debugEnableBit = 1'b0;
      cyc(2'b00, 9'h000, 1'b1);
      repeat (2) cyc(2'b00, 9'h000, 1'b0);
      debugEnableBit = 1'b1;
      for (int i = 3; i < 11; i++)
      begin
        check("word", {extB, highB, lowB}, {6'h00, expQ[i]});
        cyc(2'b00, 9'h000, 1'b1);
        repeat (2) cyc(2'b00, 9'h000, 1'b0);
      end
      check("count after reads", validWordCount, COUNT_FULL);
    end
    $display("end-type runs done");
    for (int j = 0; j < 2; j++)
    begin
      arm({j ? 4'h3 : 4'h0, !j[0], 3'b010});
      b0 = brks;
      repeat (3) cyc(2'b10, 9'h000, 1'b0);
      check("count before trigger", validWordCount, 0);
      cyc(2'b00, 9'h001, 1'b0);
      expQ.delete();
      dataFix = {1'b1, lfsr[7:0]};
      repeat (9) cyc(2'b10, 9'h002, 1'b0);
      repeat (2) cyc(2'b00, 9'h000, 1'b0);
      check("count", validWordCount, COUNT_FULL);
      check("armed", captureActiveFlag, 0);
      check("breaks", brks, b0 + 16'h0001);
      check("word", {extB, highB, lowB}, j ? {16'h0000, dataFix[7:0]} : {6'h00, expQ[0]});
      dataFix = 9'h000;
    end
    $display("begin-type runs done");
    for (int m = 0; m < 9; m++)
    begin
      arm({m[3:0], 4'b1000});
      for (int p = 0; p < 3; p++)
      begin
        cyc(2'b00, PH[p], 1'b0);
        cyc(2'b00, 9'h000, 1'b0);
        check("flags", {matchCFlag, matchAFlag, matchBFlag}, {p == 2, FE[p][m]});
      end
    end
    $display("trigger mode flags done");
    arm(8'h57);
    b0 = brks;
    cyc(2'b00, 9'h081, 1'b0);
    repeat (2) cyc(2'b00, 9'h000, 1'b0);
    check("tag break", brks, b0 + 16'h0100);
    check("armed after tag", captureActiveFlag, 1);
    @(negedge clk);
    disarmRequest = 1'b1;
    @(negedge clk);
    disarmRequest = 1'b0;
    profileMode = 1'b1;
    cyc(2'b00, 9'h000, 1'b1);
    pw = {opcodePaged, opcodeAddr};
    repeat (2) cyc(2'b00, 9'h000, 1'b1);
    cyc(2'b00, 9'h000, 1'b0);
    check("profile count", validWordCount, 4'h3);
    check("profile word", {extB, highB, lowB}, {6'h00, pw});
    profileMode = 1'b0;
    $display("tag break and profile runs done");
    results();
  end
endmodule
`default_nettype wire
